/* design/ssrl_ramp_limiter.v */
`include "ssrl_consts.vh"
module ssrl_ramp_limiter #(
  parameter SW       = `SSRL_SPD_W,
  parameter TW       = `SSRL_TIME_W,
  parameter CW       = `SSRL_SCL_W,
  parameter TICK_CYC = `SSRL_TICK_CYC
) (
  input  wire                 clock,
  input  wire                 rst,
  input  wire signed [SW-1:0] setpoint_in,
  input  wire signed [SW-1:0] actual_speed,
  input  wire                 quick_stop_command,
  input  wire [SW-1:0]        max_speed_value,
  input  wire [SW-1:0]        min_speed_value,
  input  wire                 min_speed_source_select,
  input  wire [SW-1:0]        min_speed_dyn,
  input  wire signed [SW-1:0] pos_dir_limit_value,
  input  wire                 pos_dir_limit_source,
  input  wire signed [SW-1:0] pos_dir_limit_dyn,
  input  wire signed [SW-1:0] neg_dir_limit_value,
  input  wire                 neg_dir_limit_source,
  input  wire signed [SW-1:0] neg_dir_limit_dyn,
  input  wire [4*SW-1:0]      skip_center,
  input  wire [4*SW-1:0]      skip_width,
  input  wire                 ramp_type_select,
  input  wire [TW-1:0]        ramp_up_time,
  input  wire [TW-1:0]        ramp_down_time,
  input  wire [TW-1:0]        initial_round_time,
  input  wire [TW-1:0]        final_round_time,
  input  wire                 round_type_select,
  input  wire [TW-1:0]        quick_stop_down_time,
  input  wire [TW-1:0]        quick_stop_initial_round,
  input  wire [TW-1:0]        quick_stop_final_round,
  input  wire                 up_ramp_scale_source,
  input  wire [CW-1:0]        up_ramp_scale_dyn,
  input  wire                 down_ramp_scale_source,
  input  wire [CW-1:0]        down_ramp_scale_dyn,
  output reg  signed [SW-1:0] ramp_out_r,
  output reg  signed [SW-1:0] target_r,
  output reg                  overspeed_r,
  output reg                  ramp_active_r
);
  ////////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 2'b00;
  localparam ST_CALC = 2'b01;
  localparam ST_WAIT = 2'b10;

  // Tick divider: the ramp advances once per millisecond
  reg  [31:0] tick_cnt_r;
  wire        tick = (tick_cnt_r == TICK_CYC - 1);
  always @(posedge clock or posedge rst) begin
    if (rst)
      tick_cnt_r <= 32'h00000000;
    else
      tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Limits and targets
  // minimum source
  wire [SW-1:0] min_spd = (min_speed_source_select == `SSRL_SEL_DYN) ?
                          min_speed_dyn : min_speed_value;
  wire signed [SW-1:0] pos_lim = (pos_dir_limit_source == `SSRL_SEL_DYN) ?
                                 pos_dir_limit_dyn : pos_dir_limit_value;
  wire signed [SW-1:0] neg_lim = (neg_dir_limit_source == `SSRL_SEL_DYN) ?
                                 neg_dir_limit_dyn : neg_dir_limit_value;
  wire signed [SW-1:0] max_s = max_speed_value;
  wire        sp_neg = setpoint_in[SW-1];
  wire [SW-1:0] sp_mag = sp_neg ? -setpoint_in : setpoint_in;

  // skip bands: magnitude snaps to nearer band edge
  wire [SW-1:0] band_mag [0:`SSRL_NBANDS];
  assign band_mag[0] = sp_mag;
  genvar gi;
  generate
    for (gi = 0; gi < `SSRL_NBANDS; gi = gi + 1) begin : g_band
      wire [SW-1:0] c  = skip_center[gi*SW +: SW];
      wire [SW-1:0] w  = skip_width[gi*SW +: SW];
      wire [SW-1:0] lo = (c > w) ? c - w : {SW{1'b0}};
      wire [SW-1:0] hi = c + w;
      wire          in = (w != {SW{1'b0}}) && (band_mag[gi] > lo) && (band_mag[gi] < hi);
      assign band_mag[gi+1] = !in ? band_mag[gi] : ((band_mag[gi] < c) ? lo : hi);
    end
  endgenerate

  // floor at minimum speed, clamp at maximum
  wire [SW-1:0] flr_mag = (band_mag[`SSRL_NBANDS] < min_spd) ? min_spd : band_mag[`SSRL_NBANDS];
  wire [SW-1:0] cl_mag  = (flr_mag > max_speed_value) ? max_speed_value : flr_mag;
  wire signed [SW-1:0] sgn_tgt = sp_neg ? -$signed(cl_mag) : $signed(cl_mag);
  wire signed [SW-1:0] lim_tgt = (sgn_tgt > pos_lim) ? pos_lim :
                                 (sgn_tgt < neg_lim) ? neg_lim : sgn_tgt;
  wire signed [SW-1:0] goal = quick_stop_command ? {SW{1'b0}} : lim_tgt;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      target_r    <= {SW{1'b0}};
      overspeed_r <= 1'b0;
    end else begin
      target_r <= goal;
      overspeed_r <= ((actual_speed[SW-1] ? -actual_speed : actual_speed) > max_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slope selection; decelerating when moving toward zero
  wire signed [SW-1:0] err = goal - ramp_out_r;
  wire mag_up  = (err > 0) ? !ramp_out_r[SW-1] : ramp_out_r[SW-1] || (ramp_out_r == 0);
  wire [CW-1:0] up_scl = (up_ramp_scale_source == `SSRL_SEL_DYN) ?
                         up_ramp_scale_dyn : `SSRL_SCL_ONE;
  wire [CW-1:0] dn_scl = (down_ramp_scale_source == `SSRL_SEL_DYN) ?
                         down_ramp_scale_dyn : `SSRL_SCL_ONE;
  wire [TW-1:0] base_t = quick_stop_command ? quick_stop_down_time :
                         mag_up ? ramp_up_time : ramp_down_time;
  wire [CW-1:0] scl    = (mag_up && !quick_stop_command) ? up_scl : dn_scl;
  wire [TW+CW-1:0] t_prod = base_t * scl;
  wire [SW-1:0] t_eff  = t_prod[TW+CW-1:`SSRL_SCL_FRAC] > {SW{1'b1}} ?
                         {SW{1'b1}} : t_prod[SW+`SSRL_SCL_FRAC-1:`SSRL_SCL_FRAC];
  wire [TW-1:0] r_ini = quick_stop_command ? quick_stop_initial_round : initial_round_time;
  wire [TW-1:0] r_fin = quick_stop_command ? quick_stop_final_round : final_round_time;

  // slope recomputed continuously, so edits apply mid-ramp
  reg  [1:0]    st_r;
  reg           calc_go_r;
  reg  [SW-1:0] slope_r;
  wire [SW-1:0] quo;
  wire          quo_done;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r      <= ST_IDLE;
      calc_go_r <= 1'b0;
      slope_r   <= {SW{1'b0}};
    end else begin
      calc_go_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          calc_go_r <= 1'b1;
          st_r      <= ST_CALC;
        end
        ST_CALC: st_r <= ST_WAIT;
        ST_WAIT: begin
          if (quo_done) begin
            // slope floored at one so the ramp always ends
            slope_r <= (quo == {SW{1'b0}}) ? {{(SW-1){1'b0}}, 1'b1} : quo;
            st_r    <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  ssrl_slope_calc #(
    .SW (SW)
  ) u_div (
    .clock  (clock),
    .rst    (rst),
    .start  (calc_go_r),
    .num    (max_speed_value),
    .den    (t_eff),
    .quo_r  (quo),
    .done_r (quo_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Rounding: acceleration itself ramps at slope / rounding time
  reg  [SW-1:0] acc_r;
  reg           ramp_dir_r;
  wire          ext    = (ramp_type_select == `SSRL_RAMP_EXT);
  wire [SW-1:0] abs_err = err[SW-1] ? -err : err;
  wire [TW-1:0] r_cur  = (abs_err <= acc_r * r_fin / 2) ? r_fin : r_ini;
  wire [SW-1:0] jstep  = (r_cur == {TW{1'b0}}) ? slope_r :
                         ((slope_r / r_cur) == {SW{1'b0}} ? {{(SW-1){1'b0}}, 1'b1}
                                                          : slope_r / r_cur);
  // final rounding starts at half-area braking distance
  wire          in_fin = ext && (r_fin != {TW{1'b0}}) &&
                         (abs_err <= (acc_r * r_fin) / 2);
  reg  [SW-1:0] acc_nxt;
  always @* begin
    acc_nxt = acc_r;
    if (!ext || err == 0)
      acc_nxt = ext ? {SW{1'b0}} : slope_r;
    else if (in_fin)
      acc_nxt = (acc_r > jstep) ? acc_r - jstep : jstep;
    else if (acc_r + jstep < slope_r)
      acc_nxt = acc_r + jstep;
    else
      acc_nxt = slope_r;
    // discontinuous smoothing drops rounding on a target reversal
    if (ext && round_type_select != `SSRL_ROUND_CONT && ramp_active_r &&
        (err[SW-1] != ramp_dir_r))
      acc_nxt = {SW{1'b0}};
  end

  wire [SW-1:0] step = (acc_nxt > abs_err) ? abs_err : acc_nxt;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ramp_out_r    <= {SW{1'b0}};
      acc_r         <= {SW{1'b0}};
      ramp_active_r <= 1'b0;
      ramp_dir_r    <= 1'b0;
    end else if (tick) begin
      acc_r <= acc_nxt;
      // bounded step toward target; transit only while ramping
      ramp_out_r    <= err[SW-1] ? ramp_out_r - $signed(step) : ramp_out_r + $signed(step);
      ramp_active_r <= (err != 0) && (step != abs_err);
      ramp_dir_r    <= err[SW-1];
    end
  end
endmodule // ssrl_ramp_limiter

/* pkg/ssrl_consts.vh */
`ifndef SSRL_CONSTS_VH
`define SSRL_CONSTS_VH
// Speeds are signed rpm, times are milliseconds, scales are Q8.8
`define SSRL_SPD_W          32
`define SSRL_TIME_W         24
`define SSRL_SCL_W          16
`define SSRL_SCL_ONE        16'h0100
`define SSRL_SCL_FRAC       8
`define SSRL_MAX_SPD_DEF    32'h000005DC
`define SSRL_POS_LIM_DEF    32'h00033450
`define SSRL_NEG_LIM_DEF    32'hFFFCCBB0
`define SSRL_MIN_SPD_DEF    32'h00000000
`define SSRL_RAMP_UP_DEF    24'h002710
`define SSRL_RAMP_DN_DEF    24'h002710
`define SSRL_ROUND_DEF      24'h000000
`define SSRL_QS_DN_DEF      24'h000000
`define SSRL_RAMP_EXT       1'b1
`define SSRL_ROUND_CONT     1'b0
`define SSRL_CLK_MHZ        250
`define SSRL_TICK_US        1000
`define SSRL_TICK_CYC       (`SSRL_CLK_MHZ * `SSRL_TICK_US)
`define SSRL_NBANDS         4
`define SSRL_SEL_FIXED      1'b0
`define SSRL_SEL_DYN        1'b1
`endif

/* design/ssrl_slope_calc.v */
`include "ssrl_consts.vh"
// Per-millisecond slope = max_speed / (time_ms * scale), sequential divider
module ssrl_slope_calc #(
  parameter SW = `SSRL_SPD_W
) (
  input  wire          clock,
  input  wire          rst,
  input  wire          start,
  input  wire [SW-1:0] num,
  input  wire [SW-1:0] den,
  output reg  [SW-1:0] quo_r,
  output reg           done_r
);
  // Bit count of one division
  localparam [5:0] CNT_INIT = SW;
  reg  [SW-1:0] rem_r;
  reg  [SW-1:0] q_r;
  reg  [SW-1:0] d_r;
  reg  [5:0]    cnt_r;
  reg           busy_r;
  wire [SW:0]   trial = {rem_r, q_r[SW-1]};
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rem_r  <= {SW{1'b0}};
      q_r    <= {SW{1'b0}};
      d_r    <= {SW{1'b0}};
      cnt_r  <= 6'h00;
      busy_r <= 1'b0;
      quo_r  <= {SW{1'b0}};
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        rem_r  <= {SW{1'b0}};
        q_r    <= num;
        // Zero time means an immediate step
        d_r    <= (den == {SW{1'b0}}) ? {{(SW-1){1'b0}}, 1'b1} : den;
        cnt_r  <= CNT_INIT;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (trial >= {1'b0, d_r}) begin
          rem_r <= trial[SW-1:0] - d_r;
          q_r   <= {q_r[SW-2:0], 1'b1};
        end else begin
          rem_r <= trial[SW-1:0];
          q_r   <= {q_r[SW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          quo_r  <= (trial >= {1'b0, d_r}) ? {q_r[SW-2:0], 1'b1} : {q_r[SW-2:0], 1'b0};
        end
      end
    end
  end
endmodule // ssrl_slope_calc

/* sim/ssrl_ramp_limiter_monitor.sv */
module ssrl_ramp_limiter_monitor #(
  parameter TICK_CYC = 10
) (
  input wire                clock,
  input wire                rst,
  input wire signed [31:0]  actual_speed,
  input wire                quick_stop_command,
  input wire [31:0]         max_speed_value,
  input wire [31:0]         min_speed_value,
  input wire                min_speed_source_select,
  input wire signed [31:0]  pos_dir_limit_value,
  input wire                pos_dir_limit_source,
  input wire signed [31:0]  neg_dir_limit_value,
  input wire                neg_dir_limit_source,
  input wire [127:0]        skip_center,
  input wire [127:0]        skip_width,
  input wire signed [31:0]  ramp_out_r,
  input wire signed [31:0]  target_r,
  input wire                overspeed_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  function automatic [31:0] mag(input logic signed [31:0] v);
    mag = v[31] ? -v : v;
  endfunction
  // Band edges themselves are legal resting points
  function automatic logic in_band(input logic [31:0] m, input logic [127:0] c, w);
    in_band = 1'b0;
    for (int i = 0; i < 4; i++)
      if (w[i*32+:32] != 0 && m > c[i*32+:32] - w[i*32+:32] && m < c[i*32+:32] + w[i*32+:32])
        in_band = 1'b1;
  endfunction
  ////////////////////////////////////////
  logic signed [31:0] prev_r;
  int                 gap_r;
  // Starts saturated so the first tick after reset is not flagged
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_r <= 32'h00000000;
      gap_r <= TICK_CYC;
    end else begin
      prev_r <= ramp_out_r;
      gap_r <= (ramp_out_r != prev_r) ? 0 : gap_r + 1;
    end
  end
  ////////////////////////////////////////
  sequence s_move;
    ramp_out_r != prev_r;
  endsequence
  sequence s_toward;
    ((ramp_out_r > prev_r) == (target_r > prev_r))
      && mag(ramp_out_r - prev_r) <= mag(target_r - prev_r);
  endsequence
  property p_ovs;
    overspeed_r == (mag($past(actual_speed)) > $past(max_speed_value));
  endproperty
  property p_max;
    $stable(max_speed_value) |-> mag(target_r) <= max_speed_value;
  endproperty
  property p_pos;
    $stable({pos_dir_limit_value, pos_dir_limit_source}) && !pos_dir_limit_source
      |-> target_r <= pos_dir_limit_value;
  endproperty
  property p_neg;
    $stable({neg_dir_limit_value, neg_dir_limit_source}) && !neg_dir_limit_source
      |-> target_r >= neg_dir_limit_value;
  endproperty
  property p_min;
    $stable({min_speed_value, min_speed_source_select}) && !min_speed_source_select
      |-> target_r == 0 || mag(target_r) >= min_speed_value;
  endproperty
  property p_skip;
    $stable({skip_center, skip_width}) |-> !in_band(mag(target_r), skip_center, skip_width);
  endproperty
  property p_qs;
    quick_stop_command |=> target_r == 0;
  endproperty
  property p_dir;
    s_move |-> s_toward;
  endproperty
  property p_tick;
    s_move |-> gap_r >= TICK_CYC - 1;
  endproperty
  a_ovs: assert property (p_ovs) else $error("overspeed flag wrong");
  a_max: assert property (p_max) else $error("target above max speed");
  a_pos: assert property (p_pos) else $error("target above positive limit");
  a_neg: assert property (p_neg) else $error("target below negative limit");
  a_min: assert property (p_min) else $error("target below min speed");
  a_skip: assert property (p_skip) else $error("target inside skip band");
  a_qs: assert property (p_qs) else $error("quick stop target not zero");
  a_dir: assert property (p_dir) else $error("ramp step overshoots");
  a_tick: assert property (p_tick) else $error("ramp moved between ticks");
endmodule // ssrl_ramp_limiter_monitor
bind ssrl_ramp_limiter ssrl_ramp_limiter_monitor #(.TICK_CYC(TICK_CYC)) u_ssrl_ramp_limiter_monitor (.*);

/* sim/ssrl_host_model.sv */
module ssrl_host_model (
  input  wire                clock,
  output logic signed [31:0] setpoint_in,
  output logic               up_ramp_scale_source,
  output logic [15:0]        up_ramp_scale_dyn,
  output logic               down_ramp_scale_source,
  output logic [15:0]        down_ramp_scale_dyn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    setpoint_in = 32'h00000000;
    up_ramp_scale_source = 1'b0;
    up_ramp_scale_dyn = 16'h0100;
    down_ramp_scale_source = 1'b0;
    down_ramp_scale_dyn = 16'h0100;
  end
  // Off the sampling edge, no race
  task automatic set_sp(input logic signed [31:0] v);
    @(negedge clock);
    setpoint_in = v;
  endtask
  task automatic set_scale(input logic [15:0] up, dn);
    @(negedge clock);
    up_ramp_scale_source = 1'b1;
    up_ramp_scale_dyn = up;
    down_ramp_scale_source = 1'b1;
    down_ramp_scale_dyn = dn;
  endtask
endmodule // ssrl_host_model

/* sim/tb_ssrl_ramp_limiter.sv */
module tb_ssrl_ramp_limiter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  logic clock = 1'b0, rst = 1'b1, quick_stop_command = 1'b0, round_type_select = 1'b0;
  logic min_speed_source_select = 1'b0, pos_dir_limit_source = 1'b0;
  logic neg_dir_limit_source = 1'b0, ramp_type_select = 1'b1;
  logic signed [31:0] actual_speed = 32'h00000000, setpoint_in, ramp_out_r, target_r, d;
  logic signed [31:0] pos_dir_limit_value = 32'h00033450, pos_dir_limit_dyn = 32'h00033450;
  logic signed [31:0] neg_dir_limit_value = 32'hFFFCCBB0, neg_dir_limit_dyn = 32'hFFFCCBB0;
  logic [31:0] max_speed_value = 32'h000005DC, min_speed_value = 32'h00000000;
  logic [31:0] min_speed_dyn = 32'h00000000;
  logic [127:0] skip_center = 128'h0, skip_width = 128'h0;
  logic [23:0] ramp_up_time = 24'h002710, ramp_down_time = 24'h002710;
  logic [23:0] initial_round_time = 24'h000000, final_round_time = 24'h000000;
  logic [23:0] quick_stop_down_time = 24'h000000, quick_stop_initial_round = 24'h000000;
  logic [23:0] quick_stop_final_round = 24'h000000;
  logic [15:0] up_ramp_scale_dyn, down_ramp_scale_dyn;
  logic up_ramp_scale_source, down_ramp_scale_source, overspeed_r, ramp_active_r;
  int n_mismatch = 0, checked = 0, k;
  ssrl_ramp_limiter #(.TICK_CYC(TK)) u_ssrl_ramp_limiter (.*);
  ssrl_host_model u_ssrl_host_model (.*);
  initial forever #2 clock = ~clock;
  ////////////////////////////////////////
  task automatic chk(input logic signed [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic tgt(input logic signed [31:0] sp, exp);
    u_ssrl_host_model.set_sp(sp);
    repeat (2) @(negedge clock);
    chk(target_r, exp);
  endtask
  // Phase free: waits for the next tick move
  task automatic rd_step(output logic signed [31:0] dv);
    logic signed [31:0] o;
    int n;
    o = ramp_out_r;
    n = 0;
    while (ramp_out_r === o && n < 4 * TK) begin
      @(negedge clock);
      n++;
    end
    dv = ramp_out_r - o;
  endtask
  task automatic summarize;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end
  ////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    actual_speed = 32'hFFFFFA23;
    @(negedge clock);
    chk_flag(overspeed_r, 1'b1);
    actual_speed = 32'h000005DC;
    @(negedge clock);
    chk_flag(overspeed_r, 1'b0);
    tgt(32'h000007D0, 32'h000005DC);
    tgt(32'hFFFFF830, 32'hFFFFFA24);
    min_speed_value = 32'h000000C8;
    tgt(32'h00000064, 32'h000000C8);
    min_speed_dyn = 32'h0000012C;
    min_speed_source_select = 1'b1;
    tgt(32'h00000064, 32'h0000012C);
    min_speed_source_select = 1'b0;
    min_speed_value = 32'h00000000;
    skip_center = {32'h000004B0, 64'h0, 32'h00000320};
    skip_width = {32'h00000014, 64'h0, 32'h00000032};
    tgt(32'h0000030C, 32'h000002EE);
    tgt(32'h00000334, 32'h00000352);
    tgt(32'h000004BA, 32'h000004C4);
    pos_dir_limit_value = 32'h000003E8;
    tgt(32'h00000578, 32'h000003E8);
    pos_dir_limit_dyn = 32'h00000384;
    pos_dir_limit_source = 1'b1;
    tgt(32'h00000578, 32'h00000384);
    neg_dir_limit_value = 32'hFFFFFD44;
    tgt(32'hFFFFFC7C, 32'hFFFFFD44);
    pos_dir_limit_source = 1'b0;
    pos_dir_limit_value = 32'h00033450;
    neg_dir_limit_value = 32'hFFFCCBB0;
    ramp_type_select = 1'b0;
    ramp_down_time = 24'h000000;
    tgt(32'h00000000, 32'h00000000);
    repeat (12 * TK) @(negedge clock);
    chk(ramp_out_r, 32'h00000000);
    ramp_up_time = 24'h00000A;
    ramp_down_time = 24'h00000A;
    repeat (100) @(negedge clock);
    u_ssrl_host_model.set_sp(32'h000005DC);
    rd_step(d);
    chk(d, 32'h00000096);
    repeat (12 * TK) @(negedge clock);
    chk(ramp_out_r, 32'h000005DC);
    chk_flag(ramp_active_r, 1'b0);
    u_ssrl_host_model.set_scale(16'h0200, 16'h0200);
    repeat (100) @(negedge clock);
    u_ssrl_host_model.set_sp(32'h00000000);
    rd_step(d);
    chk(d, 32'hFFFFFFB5);
    ramp_down_time = 24'h000005;
    repeat (100) @(negedge clock);
    rd_step(d);
    chk(d, 32'hFFFFFF6A);
    u_ssrl_host_model.set_scale(16'h0100, 16'h0100);
    ramp_up_time = 24'h000000;
    u_ssrl_host_model.set_sp(32'h000005DC);
    repeat (12 * TK) @(negedge clock);
    chk(ramp_out_r, 32'h000005DC);
    quick_stop_down_time = 24'h000005;
    repeat (100) @(negedge clock);
    quick_stop_command = 1'b1;
    rd_step(d);
    chk(d, 32'hFFFFFED4);
    chk(target_r, 32'h00000000);
    u_ssrl_host_model.set_sp(32'h00000000);
    repeat (8 * TK) @(negedge clock);
    quick_stop_command = 1'b0;
    ramp_type_select = 1'b1;
    ramp_up_time = 24'h00000A;
    initial_round_time = 24'h000004;
    final_round_time = 24'h000004;
    repeat (100) @(negedge clock);
    u_ssrl_host_model.set_sp(32'h000005DC);
    rd_step(d);
    chk_flag(d > 0 && d < 32'sh00000096, 1'b1);
    k = 0;
    while (ramp_out_r !== 32'h000005DC && k < 400) begin
      @(negedge clock);
      k++;
    end
    chk_flag(k >= 110 && k <= 160, 1'b1);
    summarize();
  end
endmodule // tb_ssrl_ramp_limiter
